// File: logic/sram_port_pkg.sv
// Shared constants, types and field layouts of the flow-through SRAM port.
package sram_port_pkg;
    localparam int ADDR_W      = 19;
    localparam int BURST_W     = 2;
    localparam int LANES       = 4;
    localparam int BYTE_W      = 8;
    localparam int LANE_W      = 9;
    localparam int WORD_W      = LANES * LANE_W;
    localparam int SYNC_DEPTH  = 3;
    localparam logic OE_RST    = 1'b1;
    localparam logic MODE_LIN  = 1'b0;

    typedef enum logic [1:0]
    {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } op_t;

    // One write waiting for its data phase.
    typedef struct packed
    {
        logic              pend;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane;
    } wr_slot_t;
endpackage

// File: logic/burst_seq.sv
// Two-bit burst counter with linear or interleaved order.
`timescale 1ns/10ps
`default_nettype none
module burst_seq
(
    input  wire logic       sys_clk_i,   // Core clock.
    input  wire logic       sys_rst_i,   // Synchronous reset, high.
    input  wire logic       step_en_i,   // Qualified clock edge.
    input  wire logic       load_i,      // Load a new start address.
    input  wire logic       advance_i,   // Step to the next burst slot.
    input  wire logic [1:0] start_i,     // Low address bits to seed.
    input  wire logic       linear_i,    // Linear order when high.
    output logic      [1:0] low_next_o   // Low address after this edge.
);
    logic [1:0] start_reg;
    logic [1:0] idx_reg;
    logic [1:0] idx_next;

    // Only two bits are kept, so the sequence wraps inside its group.
    always_comb
    begin
        idx_next = idx_reg;
        if (load_i)
        begin
            idx_next = 2'h0;
        end
        else if (advance_i)
        begin
            idx_next = idx_reg + 2'h1;
        end
    end

    always_comb
    begin
        if (load_i)
        begin
            low_next_o = start_i;
        end
        else if (linear_i)
        begin
            low_next_o = start_reg + idx_next;
        end
        else
        begin
            low_next_o = start_reg ^ idx_next;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            start_reg <= 2'h0;
            idx_reg   <= 2'h0;
        end
        else if (step_en_i)
        begin
            idx_reg <= idx_next;
            if (load_i)
            begin
                start_reg <= start_i;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/lane_store.sv
// Word storage in flip-flops with one write enable per byte lane.
`timescale 1ns/10ps
`default_nettype none
module lane_store
#(
    parameter int AW = 19,
    parameter int NL = 4,
    parameter int LW = 9
)
(
    input  wire logic            sys_clk_i,  // Core clock.
    input  wire logic            wr_en_i,    // Commit a write.
    input  wire logic [AW-1:0]   wr_addr_i,  // Write location.
    input  wire logic [NL-1:0]   wr_lane_i,  // Lanes to update.
    input  wire logic [NL*LW-1:0] wr_data_i, // Write word.
    input  wire logic [AW-1:0]   rd_addr_i,  // Read location.
    output logic      [NL*LW-1:0] rd_data_o  // Read word.
);
    genvar g;
    generate
        for (g = 0; g < NL; g++)
        begin : g_lane
            logic [LW-1:0] mem [0:(1<<AW)-1];

            // Parity rides in its lane, so it follows that lane's enable.
            always_ff @(posedge sys_clk_i)
            begin
                if (wr_en_i && wr_lane_i[g])
                begin
                    mem[wr_addr_i] <= wr_data_i[g*LW +: LW];
                end
            end

            assign rd_data_o[g*LW +: LW] = mem[rd_addr_i];
        end
    endgenerate
endmodule
`default_nettype wire

// File: logic/sram_port.sv
// Flow-through burst SRAM port: capture, burst, byte writes, select and drive.
`timescale 1ns/10ps
`default_nettype none
module sram_port
    import sram_port_pkg::*;
#(
    parameter int AW = sram_port_pkg::ADDR_W
)
(
    input  wire logic          sys_clk_i,              // Core clock.
    input  wire logic          sys_rst_i,              // Synchronous reset, high.
    input  wire logic [AW-1:0] addr_i,                 // Word address.
    input  wire logic          byte_lane0_write_n_i,   // Lane 0 write, low.
    input  wire logic          byte_lane1_write_n_i,   // Lane 1 write, low.
    input  wire logic          byte_lane2_write_n_i,   // Lane 2 write, low.
    input  wire logic          byte_lane3_write_n_i,   // Lane 3 write, low.
    input  wire logic          write_strobe_n_i,       // Write strobe, low.
    input  wire logic          advance_or_load_i,      // High advance, low load.
    input  wire logic          clock_qualify_n_i,      // Edge acted on when low.
    input  wire logic          chip_select_first_n_i,  // Select, low.
    input  wire logic          chip_select_second_i,   // Select, high.
    input  wire logic          chip_select_third_n_i,  // Select, low.
    input  wire logic          output_enable_n_i,      // Async drive enable, low.
    input  wire logic          burst_mode_i,           // Strap: low linear.
    input  wire logic [31:0]   dq_i,                   // Data pins in.
    input  wire logic [3:0]    dqp_i,                  // Parity pins in.
    output logic      [31:0]   dq_o,                   // Data pins out.
    output logic      [3:0]    dqp_o,                  // Parity pins out.
    output logic               dq_oe_o                 // Drive data pins, high.
);
    import sram_port_pkg::*;

    logic                  qual;
    logic                  select_now;
    logic [LANES-1:0]      lane_n;
    logic [1:0]            low_next;
    logic [AW-1:0]         addr_next;
    op_t                   op_reg;
    op_t                   op_next;
    logic [AW-3:0]         hi_reg;
    wr_slot_t              wr_reg;
    logic                  commit;
    logic                  linear_reg;
    logic [SYNC_DEPTH-1:0] oe_sync_reg;
    logic                  oe_n_reg;
    logic                  oe_n_next;
    logic [WORD_W-1:0]     pin_word;
    logic [WORD_W-1:0]     mem_word;
    logic [WORD_W-1:0]     rd_word;
    logic                  rst_q_reg;

    assign qual   = ~clock_qualify_n_i;
    assign lane_n = {byte_lane3_write_n_i, byte_lane2_write_n_i,
                     byte_lane1_write_n_i, byte_lane0_write_n_i};
    assign select_now = ~chip_select_first_n_i & chip_select_second_i
                      & ~chip_select_third_n_i;
    assign commit = qual & wr_reg.pend;

    // Next access type; an advance simply continues whatever was running.
    always_comb
    begin
        op_next = op_reg;
        if (!advance_or_load_i)
        begin
            if (!select_now)
            begin
                op_next = OP_IDLE;
            end
            else if (!write_strobe_n_i)
            begin
                op_next = OP_WRITE;
            end
            else
            begin
                op_next = OP_READ;
            end
        end
    end

    burst_seq u_burst
    (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .step_en_i  (qual),
        .load_i     (~advance_or_load_i),
        .advance_i  (advance_or_load_i),
        .start_i    (addr_i[1:0]),
        .linear_i   (linear_reg),
        .low_next_o (low_next)
    );

    // Upper bits come only from a load, so a burst cannot leave its group.
    assign addr_next = advance_or_load_i ? {hi_reg, low_next}
                                         : {addr_i[AW-1:2], low_next};

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            op_reg <= OP_IDLE;
            hi_reg <= '0;
        end
        else if (qual)
        begin
            case (op_next)
                OP_IDLE:  op_reg <= OP_IDLE;
                OP_READ:  op_reg <= OP_READ;
                OP_WRITE: op_reg <= OP_WRITE;
                default:  op_reg <= OP_IDLE;
            endcase
            if (!advance_or_load_i)
            begin
                hi_reg <= addr_i[AW-1:2];
            end
        end
    end

    // The strap is taken while reset is held, so it must be steady then.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            linear_reg <= (burst_mode_i == MODE_LIN);
        end
    end

    // Write address and lanes wait one qualified edge for their data.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_reg <= '0;
        end
        else if (qual)
        begin
            wr_reg.pend <= (op_next == OP_WRITE);
            wr_reg.addr <= ADDR_W'(addr_next);
            wr_reg.lane <= ~lane_n & {LANES{op_next == OP_WRITE}};
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_pin
            assign pin_word[g*LANE_W +: LANE_W] = {dqp_i[g], dq_i[g*BYTE_W +: BYTE_W]};
            // A read right behind a write to the same word sees the new bytes.
            assign rd_word[g*LANE_W +: LANE_W] =
                (commit && wr_reg.lane[g] && wr_reg.addr[AW-1:0] == addr_next)
                ? pin_word[g*LANE_W +: LANE_W] : mem_word[g*LANE_W +: LANE_W];
        end
    endgenerate

    lane_store #(.AW(AW), .NL(LANES), .LW(LANE_W)) u_store
    (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (commit),
        .wr_addr_i (wr_reg.addr[AW-1:0]),
        .wr_lane_i (wr_reg.lane),
        .wr_data_i (pin_word),
        .rd_addr_i (addr_next),
        .rd_data_o (mem_word)
    );

    // Read data is fetched at the starting edge, so it is valid in that cycle.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            dq_o  <= 32'h0;
            dqp_o <= 4'h0;
        end
        else if (qual && op_next == OP_READ)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                dq_o[i*BYTE_W +: BYTE_W] <= rd_word[i*LANE_W +: BYTE_W];
                dqp_o[i] <= rd_word[i*LANE_W + BYTE_W];
            end
        end
    end

    // Output enable is asynchronous; a change counts once two late stages agree.
    always_comb
    begin
        oe_n_next = oe_n_reg;
        if (oe_sync_reg[1] == oe_sync_reg[2])
        begin
            oe_n_next = oe_sync_reg[2];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            oe_sync_reg <= {SYNC_DEPTH{OE_RST}};
            oe_n_reg    <= OE_RST;
        end
        else
        begin
            oe_sync_reg <= {oe_sync_reg[SYNC_DEPTH-2:0], output_enable_n_i};
            oe_n_reg    <= oe_n_next;
        end
    end

    // Drive only in a read cycle; writes and deselect mask output enable.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            dq_oe_o <= 1'b0;
        end
        else
        begin
            dq_oe_o <= ((qual ? op_next : op_reg) == OP_READ) & ~oe_n_next;
        end
    end

    // Reset falls on a clock edge, so the checks stay off for one more edge;
    // otherwise they would compare state that reset has just cleared.
    always_ff @(posedge sys_clk_i)
    begin
        rst_q_reg <= sys_rst_i;
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i || rst_q_reg);

    property p_decode;
        qual && !advance_or_load_i |=> (op_reg != OP_IDLE) == $past(select_now);
    endproperty
    a_decode: assert property (p_decode) else $error("select decode wrong");

    property p_hold;
        !qual |=> op_reg == $past(op_reg) && wr_reg == $past(wr_reg) && hi_reg == $past(hi_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("masked edge changed state");

    property p_wstrobe;
        !qual && op_reg != OP_WRITE ##1 !qual |-> op_reg != OP_WRITE;
    endproperty
    a_wstrobe: assert property (p_wstrobe) else $error("write taken on masked edge");

    property p_wrap;
        qual && advance_or_load_i |=> hi_reg == $past(hi_reg);
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst touched upper bits");

    property p_load;
        qual && !advance_or_load_i |=> hi_reg == $past(addr_i[AW-1:2]);
    endproperty
    a_load: assert property (p_load) else $error("address not loaded");

    property p_lane;
        qual && !advance_or_load_i && select_now && !write_strobe_n_i
        |=> wr_reg.pend && wr_reg.lane == ~$past(lane_n);
    endproperty
    a_lane: assert property (p_lane) else $error("lane enables wrong");

    property p_write_hiz;
        op_reg == OP_WRITE |-> !dq_oe_o;
    endproperty
    a_write_hiz: assert property (p_write_hiz) else $error("drove during write");

    property p_desel_hiz;
        op_reg == OP_IDLE |-> !dq_oe_o;
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) else $error("drove while deselected");

    property p_oe_off;
        output_enable_n_i [*4] |=> !dq_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("drove with enable high");

    property p_read_drive;
        qual && !advance_or_load_i && select_now && write_strobe_n_i && !oe_n_next
        |=> dq_oe_o;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read did not drive");

    property p_stretch;
        !qual |=> dq_o == $past(dq_o) && dqp_o == $past(dqp_o);
    endproperty
    a_stretch: assert property (p_stretch) else $error("masked edge changed read data");
endmodule
`default_nettype wire

// File: sim/sram_ctl_model.sv
// Controller-side model that feeds requests to the port and drives write data.
`timescale 1ns/10ps
`default_nettype none
module sram_ctl_model
(
    input  wire logic        sys_clk_i, // Core clock.
    input  wire logic        qual_n_i,  // Clock qualify request, low.
    input  wire logic        we_n_i,    // Write strobe request, low.
    input  wire logic        adv_i,     // Advance request.
    input  wire logic [2:0]  sel_i,     // Selects: first_n, second, third_n.
    input  wire logic [35:0] wdata_i,   // Write word in lane order.
    output logic             adv_o,     // Advance or load to the port.
    output logic      [31:0] dq_o,      // Data pins driven.
    output logic      [3:0]  dqp_o      // Parity pins driven.
);
    logic        wr_reg = 1'b0;
    logic        desel_reg = 1'b1;
    logic        phase_reg = 1'b0;
    logic [35:0] data_reg = 36'h0;
    logic [35:0] rel_reg = 36'h0;
    logic [35:0] bus;
    logic        wr_now;

    // A burst may not continue once the port has been deselected.
    assign adv_o  = adv_i && !desel_reg;
    assign wr_now = adv_o ? wr_reg : (!we_n_i && sel_i == 3'b010);
    assign bus    = phase_reg ? data_reg : rel_reg;

    // Released lines change every cycle so a stale value is never mistaken for data.
    always @(posedge sys_clk_i)
    begin
        rel_reg <= ~rel_reg;
        if (!qual_n_i)
        begin
            wr_reg    <= wr_now;
            desel_reg <= adv_o ? desel_reg : (sel_i != 3'b010);
            phase_reg <= wr_now;
            data_reg  <= wdata_i;
        end
    end

    always_comb
    begin
        for (int g = 0; g < 4; g++)
        begin
            dq_o[8*g+:8] = bus[9*g+:8];
            dqp_o[g]     = bus[9*g+8];
        end
    end
endmodule
`default_nettype wire

// File: sim/sram_port_tb_top.sv
// Self-checking testbench of the flow-through SRAM port.
`timescale 1ns/10ps
`default_nettype none
module sram_port_tb_top;
    import sram_port_pkg::*;
    localparam logic [2:0] SEL = 3'b010;
    localparam logic [2:0] OFF = 3'b101;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        qn = 1'b0;
    logic        wn = 1'b1;
    logic        adv = 1'b0;
    logic [2:0]  sel = OFF;
    logic [3:0]  a = 4'h0;
    logic [3:0]  ln = 4'hF;
    logic [35:0] wd = 36'h0;
    logic        oen = 1'b0;
    logic        mode = 1'b0;
    logic        adv_m;
    logic [31:0] dqi;
    logic [31:0] dqo;
    logic [3:0]  dqpi;
    logic [3:0]  dqpo;
    logic        oe;
    logic [35:0] mem [16];
    int          fail_count = 0;
    int          total_checks = 0;

    always #2.5 clk = ~clk;

    sram_ctl_model ctl_u
    (
        .sys_clk_i (clk),
        .qual_n_i  (qn),
        .we_n_i    (wn),
        .adv_i     (adv),
        .sel_i     (sel),
        .wdata_i   (wd),
        .adv_o     (adv_m),
        .dq_o      (dqi),
        .dqp_o     (dqpi)
    );

    sram_port #(.AW(4)) dut_u
    (
        .sys_clk_i             (clk),
        .sys_rst_i             (rst),
        .addr_i                (a),
        .byte_lane0_write_n_i  (ln[0]),
        .byte_lane1_write_n_i  (ln[1]),
        .byte_lane2_write_n_i  (ln[2]),
        .byte_lane3_write_n_i  (ln[3]),
        .write_strobe_n_i      (wn),
        .advance_or_load_i     (adv_m),
        .clock_qualify_n_i     (qn),
        .chip_select_first_n_i (sel[2]),
        .chip_select_second_i  (sel[1]),
        .chip_select_third_n_i (sel[0]),
        .output_enable_n_i     (oen),
        .burst_mode_i          (mode),
        .dq_i                  (dqi),
        .dqp_i                 (dqpi),
        .dq_o                  (dqo),
        .dqp_o                 (dqpo),
        .dq_oe_o               (oe)
    );

    function automatic logic [35:0] rd_word();
        for (int g = 0; g < 4; g++)
            rd_word[9*g+:9] = {dqpo[g], dqo[8*g+:8]};
    endfunction

    function automatic logic [3:0] baddr(input logic m, input int i);
        baddr = m ? (4'h9 ^ 4'(i)) : {2'b10, 2'(1 + i)};
    endfunction

    task automatic op(input logic q, input logic w, input logic v, input logic [2:0] s,
                      input logic [3:0] ad, input logic [3:0] l, input logic [35:0] d);
        @(posedge clk);
        qn  <= q;
        wn  <= w;
        adv <= v;
        sel <= s;
        a   <= ad;
        ln  <= l;
        wd  <= d;
        if (!q && !v && !w && s == SEL)
            for (int g = 0; g < 4; g++)
                if (!l[g])
                    mem[ad][9*g+:9] = d[9*g+:9];
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic t_wr_rd();
        op(0, 0, 0, SEL, 4'h5, 4'h0, 36'h9_1234_5678);
        op(0, 0, 0, SEL, 4'h6, 4'h0, 36'h3_CAFE_0F0F);
        #1 chk({35'h0, oe}, 36'h0);
        op(0, 0, 0, SEL, 4'h5, 4'hA, 36'hF_FFFF_FFFF);
        op(0, 1, 0, SEL, 4'h5, 4'hF, 36'h0);
        op(0, 1, 0, SEL, 4'h6, 4'hF, 36'h0);
        #1 chk(rd_word(), mem[5]);
        op(0, 1, 0, OFF, 4'h0, 4'hF, 36'h0);
        #1 chk(rd_word(), mem[6]);
        chk({35'h0, oe}, 36'h1);
    endtask

    task automatic t_mask();
        op(0, 1, 0, SEL, 4'h5, 4'hF, 36'h0);
        repeat (2) op(1, 0, 0, OFF, 4'h6, 4'h0, 36'h0);
        repeat (2) op(1, 0, 0, SEL, 4'h6, 4'h0, 36'h0);
        #1 chk(rd_word(), mem[5]);
        chk({35'h0, oe}, 36'h1);
        op(0, 1, 0, SEL, 4'h6, 4'hF, 36'h0);
        op(0, 1, 0, OFF, 4'h0, 4'hF, 36'h0);
        #1 chk(rd_word(), mem[6]);
    endtask

    task automatic t_desel();
        for (int k = 0; k < 8; k++)
            if (3'(k) != SEL)
            begin
                op(0, 1, 0, 3'(k), 4'h5, 4'hF, 36'h0);
                op(0, 1, 1, SEL, 4'h5, 4'hF, 36'h0);
                #1 chk({35'h0, oe}, 36'h0);
            end
    endtask

    task automatic t_oe();
        op(0, 1, 0, SEL, 4'h6, 4'hF, 36'h0);
        oen <= 1'b1;
        repeat (5) op(0, 1, 0, SEL, 4'h6, 4'hF, 36'h0);
        #1 chk({35'h0, oe}, 36'h0);
        op(0, 1, 0, SEL, 4'h6, 4'hF, 36'h0);
        oen <= 1'b0;
        repeat (4) op(0, 1, 0, SEL, 4'h6, 4'hF, 36'h0);
        #1 chk({35'h0, oe}, 36'h1);
    endtask

    task automatic t_burst(input logic m);
        @(posedge clk);
        rst  <= 1'b1;
        mode <= m;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            op(0, 0, i != 0, SEL, 4'h9, 4'h0, 36'h1_0000_0000 + 36'(i));
            mem[baddr(m, i)] = 36'h1_0000_0000 + 36'(i);
        end
        for (int i = 0; i < 5; i++)
        begin
            op(0, 1, i > 0 && i < 4, i < 4 ? SEL : OFF, 4'h9, 4'hF, 36'h0);
            if (i > 0)
            begin
                #1 chk(rd_word(), mem[baddr(m, i - 1)]);
            end
        end
        for (int j = 8; j < 13; j++)
        begin
            op(0, 1, 0, j < 12 ? SEL : OFF, 4'(j), 4'hF, 36'h0);
            if (j > 8)
            begin
                #1 chk(rd_word(), mem[j - 1]);
            end
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (2000) @(posedge clk);
        fail_count++;
        final_report();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) op(0, 1, 0, OFF, 4'h0, 4'hF, 36'h0);
        t_wr_rd();
        t_mask();
        t_desel();
        t_oe();
        t_burst(1'b0);
        t_burst(1'b1);
        final_report();
    end
endmodule
`default_nettype wire
